// *** rtl/blx_exec.v ***
// execution of byte and, bit clear, bit set and bit test-skip
// assumes fetch supplies instr with instr_valid and register file
// answers reads combinationally on f_rdata
//
// Summary of operation
// - and accumulator with addressed register, update zero flag from result
// - destination bit zero writes result to accumulator only
// - destination bit one writes result back into addressed register
// - bit clear op clears chosen bit, others and flags untouched
// - bit set op sets chosen bit, others and flags untouched
// - test skip on zero op skips next instruction when bit is zero
// - port registers modified from own value use pin levels as operand
// - write to timer count register clears prescaler if assigned to timer
`timescale 1ns/10ps
`default_nettype none
`include "blx_defs.vh"
module blx_exec (
    input wire clk,
    input wire resetn,
    input wire [11:0] instr,
    input wire instr_valid,
    output wire [4:0] f_addr,
    input wire [7:0] f_rdata,
    input wire [7:0] pin_porta,
    input wire [7:0] pin_portb,
    input wire [7:0] pin_portc,
    input wire psa_to_timer,
    output reg f_we_q,
    output reg [4:0] f_waddr_q,
    output reg [7:0] f_wdata_q,
    output reg [7:0] acc_q,
    output reg zero_q,
    output reg flush_q,
    output reg prescaler_clr_q,
    output wire busy
);
// ==========================================
// local codes
localparam ST_RUN = 1'b0;
localparam ST_DROP = 1'b1;
localparam [2:0] OP_NONE = 3'h0;
localparam [2:0] OP_AND = 3'h1;
localparam [2:0] OP_BCLR = 3'h2;
localparam [2:0] OP_BSET = 3'h3;
localparam [2:0] OP_BTST = 3'h4;
// ==========================================
// pin synchronisers, three stages
wire [23:0] pin_raw = {pin_portc, pin_portb, pin_porta};
reg [23:0] pin_s1_q;
reg [23:0] pin_s2_q;
reg [23:0] pin_s3_q;
reg [23:0] pin_q;
reg [23:0] pin_d;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pin_s1_q <= 24'h000000;
    end else begin
        pin_s1_q <= pin_raw;
    end
end
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pin_s2_q <= 24'h000000;
    end else begin
        pin_s2_q <= pin_s1_q;
    end
end
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pin_s3_q <= 24'h000000;
    end else begin
        pin_s3_q <= pin_s2_q;
    end
end
// change taken once second and third stages agree
always @* begin
    pin_d = (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
end
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pin_q <= 24'h000000;
    end else begin
        pin_q <= pin_d;
    end
end
// ==========================================
// decode
wire [4:0] faddr = instr[4:0];
wire [2:0] pos = instr[`BLX_BIT_POS_HI:`BLX_BIT_POS_LO];
wire dest_f = instr[`BLX_BIT_D];
wire [5:0] op_hi6 = instr[11:6];
wire [3:0] op_hi4 = instr[11:8];
reg state_d;
// instruction behind a taken skip is dropped
wire take = instr_valid && (flush_q == ST_RUN);
reg [2:0] op_cls;
always @* begin
    op_cls = OP_NONE;
    if (take) begin
        if (op_hi6 == `BLX_OP_AND) begin
            op_cls = OP_AND;
        end else begin
            case (op_hi4)
                `BLX_OP_BCLR: op_cls = OP_BCLR;
                `BLX_OP_BSET: op_cls = OP_BSET;
                `BLX_OP_BTSTZ: op_cls = OP_BTST;
                default: op_cls = OP_NONE;
            endcase
        end
    end
end
wire is_and = op_cls == OP_AND;
wire is_bclr = op_cls == OP_BCLR;
wire is_bset = op_cls == OP_BSET;
wire is_btst = op_cls == OP_BTST;
wire [7:0] mask;
blx_bit_mask u_mask (
    .pos(pos),
    .mask(mask)
);
assign f_addr = faddr;
assign busy = flush_q;
// ==========================================
// operand selection
wire modifies_f = is_and || is_bclr || is_bset;
reg [7:0] opnd;
always @* begin
    opnd = f_rdata;
    if (modifies_f) begin
        case (faddr)
            `BLX_FADDR_PORTA: opnd = pin_q[7:0];
            `BLX_FADDR_PORTB: opnd = pin_q[15:8];
            `BLX_FADDR_PORTC: opnd = pin_q[23:16];
            default: opnd = f_rdata;
        endcase
    end
end
wire [7:0] and_res = acc_q & opnd;
wire writes_f = (is_and && dest_f) || is_bclr || is_bset;
wire hits_timer = faddr == `BLX_FADDR_TMR;
wire bit_zero = (f_rdata & mask) == 8'h00;
// ==========================================
// next values
reg [7:0] acc_d;
reg zero_d;
reg [7:0] f_wdata_d;
reg f_we_d;
reg prescaler_clr_d;
always @* begin
    acc_d = acc_q;
    zero_d = zero_q;
    f_wdata_d = f_wdata_q;
    case (op_cls)
        OP_AND: begin
            zero_d = and_res == 8'h00;
            if (dest_f) begin
                f_wdata_d = and_res;
            end else begin
                acc_d = and_res;
            end
        end
        OP_BCLR: begin
            f_wdata_d = opnd & ~mask;
        end
        OP_BSET: begin
            f_wdata_d = opnd | mask;
        end
        default: begin
            f_wdata_d = f_wdata_q;
        end
    endcase
end
always @* begin
    f_we_d = writes_f;
    prescaler_clr_d = writes_f && hits_timer && psa_to_timer;
end
// ==========================================
// skip state
always @* begin
    case (flush_q)
        ST_RUN: begin
            if (is_btst && bit_zero) begin
                state_d = ST_DROP;
            end else begin
                state_d = ST_RUN;
            end
        end
        ST_DROP: begin
            state_d = ST_RUN;
        end
        default: begin
            state_d = ST_RUN;
        end
    endcase
end
// ==========================================
// registers
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        f_we_q <= 1'b0;
        f_waddr_q <= 5'h00;
        f_wdata_q <= 8'h00;
    end else begin
        f_we_q <= f_we_d;
        f_waddr_q <= faddr;
        f_wdata_q <= f_wdata_d;
    end
end
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        acc_q <= `BLX_ACC_RST;
        zero_q <= 1'b0;
    end else begin
        acc_q <= acc_d;
        zero_q <= zero_d;
    end
end
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        flush_q <= ST_RUN;
    end else begin
        flush_q <= state_d;
    end
end
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        prescaler_clr_q <= 1'b0;
    end else begin
        prescaler_clr_q <= prescaler_clr_d;
    end
end
endmodule
`default_nettype wire

// *** shared/blx_defs.vh ***
// constants for the bit and logic execution block
// assumes inclusion by bare name from rtl files
`ifndef BLX_DEFS_VH
`define BLX_DEFS_VH
`define BLX_OP_AND 6'h05
`define BLX_OP_BCLR 4'h4
`define BLX_OP_BSET 4'h5
`define BLX_OP_BTSTZ 4'h6
`define BLX_INSTR_NOP 12'h000
`define BLX_ACC_RST 8'h00
`define BLX_FADDR_TMR 5'h01
`define BLX_FADDR_PORTA 5'h05
`define BLX_FADDR_PORTB 5'h06
`define BLX_FADDR_PORTC 5'h07
`define BLX_BIT_D 5
`define BLX_BIT_POS_HI 7
`define BLX_BIT_POS_LO 5
`endif

// *** rtl/blx_bit_mask.v ***
// one-hot bit mask from a three-bit position
// assumes nothing beyond a combinational consumer
`timescale 1ns/10ps
`default_nettype none
module blx_bit_mask (
    input wire [2:0] pos,
    output wire [7:0] mask
);
// ==========================================
// decoder
assign mask = 8'h01 << pos;
endmodule
`default_nettype wire

// *** tb/blx_rf.sv ***
// register file model, read answers at once
`timescale 1ns/10ps
`default_nettype none
module blx_rf (input wire logic [4:0] f_addr, output logic [7:0] f_rdata);
assign f_rdata = {3'h5, f_addr};
endmodule
`default_nettype wire

// *** tb/blx_exec_sva.sv ***
// blx_exec checker, one clock, reset low
`timescale 1ns/10ps
`default_nettype none
module blx_exec_sva (
input wire clk, resetn, instr_valid, f_we_q, zero_q, flush_q,
input wire psa_to_timer, prescaler_clr_q, busy,
input wire [4:0] f_waddr_q,
input wire [11:0] instr,
input wire [7:0] f_rdata, acc_q, f_wdata_q);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire [7:0] m = 8'h01 << instr[7:5];
wire [7:0] r = acc_q & f_rdata;
wire t = instr_valid && !flush_q && instr[4:2] != 3'h1;
wire [3:0] o = t ? instr[11:8] : 4'h0;
wire a = t && instr[11:6] == 6'h05;
wire k = o == 4'h6 && !(f_rdata & m);
wire w = instr_valid && !flush_q && instr[4:0] == 5'h01 &&
    (instr[11:8] == 4'h4 || instr[11:8] == 4'h5 || instr[11:5] == 7'h0b);
sequence s_k; flush_q ##1 !flush_q; endsequence
property p_p; w && psa_to_timer |=> prescaler_clr_q; endproperty
a_p: assert property (p_p) else $error("prescaler");
property p_q; !(w && psa_to_timer) |=> !prescaler_clr_q; endproperty
a_q: assert property (p_q) else $error("no prescaler");
property p_b; busy == flush_q; endproperty
a_b: assert property (p_b) else $error("busy");
property p_a; o == 4'h4 || o == 4'h5 || a && instr[5] |=>
    f_waddr_q == $past(instr[4:0]); endproperty
a_a: assert property (p_a) else $error("address");
property p_z; a |=> zero_q == !$past(r); endproperty
a_z: assert property (p_z) else $error("zero");
property p_w; a && !instr[5] |=> !f_we_q && acc_q == $past(r); endproperty
a_w: assert property (p_w) else $error("acc");
property p_f; a && instr[5] |=> f_we_q && f_wdata_q == $past(r); endproperty
a_f: assert property (p_f) else $error("reg");
property p_c; o == 4'h4 |=> f_we_q && f_wdata_q == $past(f_rdata & ~m);
endproperty
a_c: assert property (p_c) else $error("clr");
property p_s; o == 4'h5 |=> f_we_q && f_wdata_q == $past(f_rdata | m);
endproperty
a_s: assert property (p_s) else $error("set");
property p_k; k |=> s_k; endproperty
a_k: assert property (p_k) else $error("skip");
property p_n; o == 4'h6 && !k |=> !flush_q && $stable(zero_q); endproperty
a_n: assert property (p_n) else $error("test");
property p_d; flush_q |=> !f_we_q && $stable(acc_q); endproperty
a_d: assert property (p_d) else $error("drop");
endmodule
bind blx_exec blx_exec_sva u_sva (.*);
`default_nettype wire

// *** tb/test_bit_and_logic_instr_exec.sv ***
// bench for blx_exec, register file model on its read side
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) comparisons++; if ((g) !== (e)) begin fail_count++; \
$display("wrong value %0t %h %h", $time, g, e); end
module test_bit_and_logic_instr_exec;
logic clk = 0, resetn = 0, instr_valid = 0, f_we_q, zero_q, flush_q, busy;
logic psa_to_timer = 0, prescaler_clr_q;
logic [11:0] instr = 12'h0;
logic [7:0] f_rdata, f_wdata_q, acc_q;
logic [7:0] pin_porta = 8'h0, pin_portb = 8'h0, pin_portc = 8'h0;
logic [4:0] f_addr, f_waddr_q;
int fail_count = 0, comparisons = 0;
blx_exec u_dut (.*);
blx_rf u_rf (.*);
task run(input logic [11:0] x, y);
@(posedge clk) instr <= x;
instr_valid <= 1'h1;
@(posedge clk) instr <= y;
@(posedge clk) instr_valid <= 1'h0;
@(negedge clk);
endtask
task t_and;
run(12'h0, 12'h162);
`CK({f_we_q, f_wdata_q, zero_q}, 10'h201)
run(12'h0, 12'h142);
`CK({f_we_q, acc_q, zero_q}, 10'h001)
endtask
task t_bit;
logic [7:0] m;
for (int k = 8; k < 24; k++) begin
m = 8'h01 << k[2:0];
run(12'h0, {3'h2, k[4], k[2:0], 5'h03});
`CK({zero_q, f_wdata_q}, {1'h1, k[4] ? 8'ha3 | m : 8'ha3 & ~m})
end
endtask
task t_skip;
run(12'h643, 12'h5e3);
`CK({f_we_q, flush_q}, 2'h0)
run(12'h603, 12'h5e3);
`CK({f_we_q, flush_q}, 2'h2)
run(12'h5e3, 12'h643);
`CK({f_we_q, flush_q, busy}, 3'h3)
endtask
task t_reset;
@(negedge clk);
`CK({f_we_q, flush_q, busy, acc_q, zero_q, prescaler_clr_q}, 13'h0)
endtask
task t_port;
@(posedge clk) pin_porta <= 8'h5a;
pin_portb <= 8'hff;
pin_portc <= 8'h3c;
repeat (5) @(posedge clk);
run(12'h0, 12'h505);
`CK({f_we_q, f_waddr_q, f_wdata_q}, {1'h1, 5'h05, 8'h5b})
run(12'h0, 12'h426);
`CK({f_we_q, f_waddr_q, f_wdata_q}, {1'h1, 5'h06, 8'hfd})
run(12'h0, 12'h5e7);
`CK({f_we_q, f_waddr_q, f_wdata_q}, {1'h1, 5'h07, 8'hbc})
endtask
task t_timer;
@(posedge clk) psa_to_timer <= 1'h1;
run(12'h0, 12'h501);
`CK({prescaler_clr_q, f_waddr_q}, {1'h1, 5'h01})
run(12'h0, 12'h141);
`CK(prescaler_clr_q, 1'h0)
@(posedge clk) psa_to_timer <= 1'h0;
run(12'h0, 12'h501);
`CK({prescaler_clr_q, f_we_q}, 2'h1)
endtask
task summarize;
if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
else $display("DONE - FAIL");
$finish;
endtask
initial forever #10 clk = ~clk;
initial begin
repeat (5) @(posedge clk);
resetn <= 1'h1;
t_reset;
t_and;
t_bit;
t_port;
t_timer;
t_skip;
summarize;
end
initial begin
#10000 fail_count++;
summarize;
end
endmodule
`default_nettype wire
